// ===== src/acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// APB byte offsets of the block's registers
`define ACS_OFF_CTRL_A 12'h000
`define ACS_OFF_CTRL_B 12'h004
`define ACS_OFF_CHAN 12'h008
`define ACS_OFF_RES_LO 12'h00C
`define ACS_OFF_RES_HI 12'h010
// Control A fields
`define ACS_A_EN 7
`define ACS_A_START 6
`define ACS_A_ATE 5
`define ACS_A_FLAG 4
`define ACS_A_PS_LSB 0
// Channel register fields
`define ACS_C_REF_LSB 6
`define ACS_C_LADJ 5
`define ACS_C_MUX_LSB 0
// Conversion lengths in converter clock cycles
`define ACS_NORMAL_CYC 5'd13
`define ACS_FIRST_CYC 5'd25
`define ACS_DIFF_CYC 5'd14
`define ACS_AUTO_CYC 5'd14
// Sample instants, in half converter cycles from start
`define ACS_SH_NORMAL_HALF 6'd3
`define ACS_SH_FIRST_HALF 6'd27
`define ACS_SH_AUTO_HALF 6'd4
// Trigger select code meaning free running
`define ACS_TRIG_FREE 3'h0
`define ACS_RESET_WORD 8'h00
`endif

// ===== src/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {ACS_IDLE, ACS_WAIT, ACS_CONV} acs_state_e;
  typedef logic [9:0] acs_result_t;
endpackage

// ===== src/acs_clk_if.sv
`timescale 1ns/1ps
interface acs_clk_if;
  logic enable;
  logic restart;
  logic [2:0] ps_sel;
  logic tick;
  logic half_tick;
  logic half_phase;
  modport ctrl (output enable, output restart, output ps_sel,
                input tick, input half_tick, input half_phase);
  modport pre (input enable, input restart, input ps_sel,
               output tick, output half_tick, output half_phase);
endinterface

// ===== src/acs_prescaler.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_prescaler import acs_pkg::*; #(
  parameter int CNT_W = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  acs_clk_if.pre pif
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic phase;
  } acs_pre_s;
  acs_pre_s st_r;
  acs_pre_s st_nxt;
  logic [CNT_W:0] period;
  logic wrap;

  // Division is 2 to the power of the select, minimum 2
  always_comb begin
    period = (CNT_W+1)'(1) << ((pif.ps_sel == 3'h0) ? 3'h1 : pif.ps_sel);
    wrap = ({1'b0, st_r.cnt} == period - (CNT_W+1)'(1));
    st_nxt = st_r;
    if (!pif.enable || pif.restart) begin
      st_nxt.cnt = '0;
      st_nxt.phase = 1'b0;
    end else if (wrap) begin
      st_nxt.cnt = '0;
      st_nxt.phase = ~st_r.phase;
    end else begin
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
    end
  end

  assign pif.tick = pif.enable && !pif.restart && wrap;
  assign pif.half_tick = pif.enable && !pif.restart
                         && (st_r.cnt == CNT_W'(period[CNT_W:1] - (CNT_W+1)'(1)));
  assign pif.half_phase = st_r.phase;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ===== src/acs_sequencer.sv
`timescale 1ns/1ps
`include "acs_cfg.svh"
// How it works
// - 10-bit result, zero is ground
// - selections apply only while enabled
// - right aligned, left when adjust set
// - low byte read locks both bytes
// - high byte read unlocks result bytes
// - flag set even when result dropped
// - start bit runs one conversion, self-clears
// - channel change waits for conversion end
// - trigger edge restarts prescaler, starts conversion
// - edges during conversion ignored
// - source flag must clear between triggers
// - done-flag source runs free
// - start reads one while busy
// - prescaler held reset while disabled
// - software start on next converter edge
// - 13 cycles, first after enable 25
// - sample at 1.5, first at 13.5
// - completion writes result, sets flag
// - auto trigger sample at 2 cycles
// - free run restarts at once
// - differential aligns to half-rate clock
// - selection frozen during conversion
module acs_sequencer import acs_pkg::*; #(
  parameter int TRIG_N = 8
) (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [TRIG_N-1:0] TRIGGER_I,
  input wire logic [9:0] CONV_DATA_I,
  input wire logic DIFF_CHANNEL_I,
  output logic [4:0] INPUT_CHANNEL_SELECT_O,
  output logic [1:0] REFERENCE_SELECT_O,
  output logic CONV_ENABLE_O,
  output logic SAMPLE_HOLD_O,
  output logic CONV_BUSY_O,
  output logic CONV_DONE_FLAG_O
);
  typedef struct packed {
    acs_state_e state;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] chan;
    logic [6:0] held_sel;
    logic [9:0] result;
    logic locked;
    logic first;
    logic auto_run;
    logic sampled;
    logic [4:0] cyc_left;
    logic [5:0] half_cnt;
    logic [5:0] sh_half;
    logic [TRIG_N-1:0] trig_s1;
    logic [TRIG_N-1:0] trig_s2;
    logic trig_prev;
    logic [31:0] rdata;
    logic sh_pulse;
  } acs_seq_s;

  acs_seq_s st_r;
  acs_seq_s st_nxt;
  acs_clk_if cif();

  logic wr_en;
  logic rd_en;
  logic trig_lvl;
  logic trig_rise;
  logic enable;
  logic [2:0] tsel;
  logic free_run;
  logic sw_start;
  logic auto_start;
  logic finish;
  logic [15:0] aligned;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic lane);
    merge_byte = lane ? new_v : old_v;
  endfunction

  function automatic logic [15:0] align(input logic [9:0] r, input logic ladj);
    align = ladj ? {r, 6'h00} : {6'h00, r};
  endfunction

  // Offsets that answer; anything else is refused with an error
  function automatic logic reg_hit(input logic [11:0] a);
    case (a)
      `ACS_OFF_CTRL_A: reg_hit = 1'b1;
      `ACS_OFF_CTRL_B: reg_hit = 1'b1;
      `ACS_OFF_CHAN: reg_hit = 1'b1;
      `ACS_OFF_RES_LO: reg_hit = 1'b1;
      `ACS_OFF_RES_HI: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input logic [11:0] a, input logic [7:0] ca,
                                          input logic [7:0] cb, input logic [7:0] ch,
                                          input logic [15:0] al);
    case (a)
      `ACS_OFF_CTRL_A: rd_word = {24'h000000, ca};
      `ACS_OFF_CTRL_B: rd_word = {24'h000000, cb};
      `ACS_OFF_CHAN: rd_word = {24'h000000, ch};
      `ACS_OFF_RES_LO: rd_word = {24'h000000, al[7:0]};
      `ACS_OFF_RES_HI: rd_word = {24'h000000, al[15:8]};
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [4:0] conv_len(input logic first_v, input logic auto_v,
                                          input logic long_v);
    if (first_v) begin
      conv_len = `ACS_FIRST_CYC;
    end else if (auto_v) begin
      conv_len = `ACS_AUTO_CYC;
    end else if (long_v) begin
      conv_len = `ACS_DIFF_CYC;
    end else begin
      conv_len = `ACS_NORMAL_CYC;
    end
  endfunction

  // sample instant in half converter cycles
  function automatic logic [5:0] sample_at(input logic first_v, input logic auto_v,
                                           input logic long_v);
    if (first_v) begin
      sample_at = `ACS_SH_FIRST_HALF;
    end else if (auto_v) begin
      sample_at = `ACS_SH_AUTO_HALF;
    end else if (long_v) begin
      sample_at = `ACS_SH_NORMAL_HALF + 6'd2;
    end else begin
      sample_at = `ACS_SH_NORMAL_HALF;
    end
  endfunction

  acs_prescaler #(.CNT_W(7)) u_pre (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .pif(cif.pre)
  );

  assign enable = st_r.ctrl_a[`ACS_A_EN];
  assign tsel = st_r.ctrl_b[2:0];
  assign free_run = st_r.ctrl_a[`ACS_A_ATE] && (tsel == `ACS_TRIG_FREE);
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
  // Trigger taken only after two flops; the first stage feeds nothing else
  assign trig_lvl = st_r.trig_s2[tsel];
  // only a fresh rising edge counts
  // A source left high never retriggers, so software must drop it first
  assign trig_rise = trig_lvl && !st_r.trig_prev;
  assign sw_start = wr_en && (PADDR_I == `ACS_OFF_CTRL_A) && PSTRB_I[0]
                    && PWDATA_I[`ACS_A_START] && PWDATA_I[`ACS_A_EN];
  assign auto_start = enable && st_r.ctrl_a[`ACS_A_ATE] && !free_run && trig_rise;
  assign finish = (st_r.state == ACS_CONV) && cif.tick && (st_r.cyc_left == 5'd1);
  assign aligned = align(st_r.result, st_r.chan[`ACS_C_LADJ]);

  assign cif.enable = enable;
  assign cif.restart = auto_start && (st_r.state == ACS_IDLE);
  assign cif.ps_sel = st_r.ctrl_a[2:0];

  always_comb begin
    st_nxt = st_r;
    st_nxt.sh_pulse = 1'b0;
    st_nxt.trig_s1 = TRIGGER_I;
    st_nxt.trig_s2 = st_r.trig_s1;
    st_nxt.trig_prev = trig_lvl;

    if (st_r.state != ACS_CONV || (finish)) begin
      st_nxt.held_sel = {st_r.chan[7:6], st_r.chan[4:0]};
    end

    if (wr_en) begin
      case (PADDR_I)
        `ACS_OFF_CTRL_A: begin
          if (PSTRB_I[0]) begin
            st_nxt.ctrl_a[`ACS_A_EN] = PWDATA_I[`ACS_A_EN];
            st_nxt.ctrl_a[`ACS_A_ATE] = PWDATA_I[`ACS_A_ATE];
            st_nxt.ctrl_a[3:0] = PWDATA_I[3:0];
            // Flag clears by writing one
            if (PWDATA_I[`ACS_A_FLAG]) begin
              st_nxt.ctrl_a[`ACS_A_FLAG] = 1'b0;
            end
          end
        end
        `ACS_OFF_CTRL_B: st_nxt.ctrl_b = merge_byte(st_r.ctrl_b, PWDATA_I[7:0], PSTRB_I[0]);
        `ACS_OFF_CHAN: st_nxt.chan = merge_byte(st_r.chan, PWDATA_I[7:0], PSTRB_I[0]);
        default: st_nxt.ctrl_b = st_r.ctrl_b;
      endcase
    end

    if (rd_en) begin
      if (PADDR_I == `ACS_OFF_RES_LO) begin
        st_nxt.locked = 1'b1;
      end
      if (PADDR_I == `ACS_OFF_RES_HI) begin
        st_nxt.locked = 1'b0;
      end
    end

    // disable drops everything in flight
    // A write that sets enable and start together still starts from idle
    if (!enable && !(sw_start && st_r.state == ACS_IDLE)) begin
      st_nxt.state = ACS_IDLE;
      st_nxt.first = 1'b1;
      st_nxt.ctrl_a[`ACS_A_START] = 1'b0;
    end else begin
      case (st_r.state)
        ACS_IDLE: begin
          // software start waits for converter edge
          if (sw_start) begin
            st_nxt.state = ACS_WAIT;
            st_nxt.auto_run = 1'b0;
            st_nxt.ctrl_a[`ACS_A_START] = 1'b1;
          end else if (auto_start) begin
            st_nxt.state = ACS_CONV;
            st_nxt.auto_run = 1'b1;
            st_nxt.ctrl_a[`ACS_A_START] = 1'b1;
            st_nxt.cyc_left = conv_len(st_r.first, 1'b1, 1'b0);
            st_nxt.sh_half = sample_at(st_r.first, 1'b1, 1'b0);
            st_nxt.half_cnt = '0;
            st_nxt.sampled = 1'b0;
          end
        end
        ACS_WAIT: begin
          if (cif.tick) begin
            st_nxt.state = ACS_CONV;
            st_nxt.half_cnt = '0;
            st_nxt.sampled = 1'b0;
            if (st_r.first) begin
              st_nxt.cyc_left = `ACS_FIRST_CYC;
              st_nxt.sh_half = `ACS_SH_FIRST_HALF;
            end else if (DIFF_CHANNEL_I && cif.half_phase) begin
              st_nxt.cyc_left = `ACS_DIFF_CYC;
              st_nxt.sh_half = `ACS_SH_NORMAL_HALF + 6'd2;
            end else begin
              st_nxt.cyc_left = `ACS_NORMAL_CYC;
              st_nxt.sh_half = `ACS_SH_NORMAL_HALF;
            end
          end
        end
        ACS_CONV: begin
          if (cif.tick || cif.half_tick) begin
            st_nxt.half_cnt = st_r.half_cnt + 6'd1;
          end
          if (!st_r.sampled && (cif.tick || cif.half_tick)
              && (st_r.half_cnt + 6'd1 == st_r.sh_half)) begin
            st_nxt.sampled = 1'b1;
            st_nxt.sh_pulse = 1'b1;
          end
          if (cif.tick && st_r.cyc_left != 5'd1) begin
            st_nxt.cyc_left = st_r.cyc_left - 5'd1;
          end
          if (finish) begin
            st_nxt.first = 1'b0;
            st_nxt.ctrl_a[`ACS_A_FLAG] = 1'b1;
            if (!st_r.locked) begin
              // full 10-bit code kept as delivered
              st_nxt.result = CONV_DATA_I;
            end
            if (free_run) begin
              st_nxt.state = ACS_CONV;
              st_nxt.half_cnt = '0;
              st_nxt.sampled = 1'b0;
              // free running differential is always long
              st_nxt.cyc_left = conv_len(1'b0, 1'b0, DIFF_CHANNEL_I);
              st_nxt.sh_half = sample_at(1'b0, 1'b0, DIFF_CHANNEL_I);
            end else begin
              // level still high does not restart
              st_nxt.state = ACS_IDLE;
              st_nxt.ctrl_a[`ACS_A_START] = 1'b0;
            end
          end
        end
        default: st_nxt.state = ACS_IDLE;
      endcase
    end

    if (enable && st_nxt.state != ACS_IDLE) begin
      st_nxt.ctrl_a[`ACS_A_START] = 1'b1;
    end

    // Read data is registered in setup so it is stable for the access phase
    st_nxt.rdata = 32'h0000_0000;
    if (PSEL_I && !PENABLE_I) begin
      st_nxt.rdata = rd_word(PADDR_I, st_r.ctrl_a, st_r.ctrl_b, st_r.chan, aligned);
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      st_r <= '0;
      st_r.state <= ACS_IDLE;
      st_r.first <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA_O = st_r.rdata;
  // No wait states: every register answers in the access cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !reg_hit(PADDR_I);
  assign INPUT_CHANNEL_SELECT_O = enable ? st_r.held_sel[4:0] : 5'h00;
  assign REFERENCE_SELECT_O = enable ? st_r.held_sel[6:5] : 2'h0;
  assign CONV_ENABLE_O = enable;
  assign SAMPLE_HOLD_O = st_r.sh_pulse;
  assign CONV_BUSY_O = st_r.state == ACS_CONV;
  assign CONV_DONE_FLAG_O = st_r.ctrl_a[`ACS_A_FLAG];
endmodule

// ===== bench/acs_sequencer_monitor.sv
`timescale 1ns/1ps
module acs_sequencer_monitor (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic [4:0] INPUT_CHANNEL_SELECT_O,
  input wire logic [1:0] REFERENCE_SELECT_O,
  input wire logic CONV_ENABLE_O,
  input wire logic SAMPLE_HOLD_O,
  input wire logic CONV_BUSY_O,
  input wire logic CONV_DONE_FLAG_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  wire acc_w = PSEL_I && PENABLE_I;
  wire [6:0] sel_w = {REFERENCE_SELECT_O, INPUT_CHANNEL_SELECT_O};
  sequence s_start;
    $rose(CONV_BUSY_O);
  endsequence
  sequence s_end;
    $fell(CONV_BUSY_O) && CONV_ENABLE_O;
  endsequence
  chk_ready_high: assert property (PREADY_O) else $error("ready low");
  chk_err_unmapped: assert property (acc_w && PADDR_I > 12'h010 |-> PSLVERR_O)
    else $error("unmapped not refused");
  chk_err_mapped: assert property (acc_w && PADDR_I[1:0] == 2'h0 && PADDR_I <= 12'h010
    |-> !PSLVERR_O) else $error("mapped refused");
  chk_off_zero: assert property (!CONV_ENABLE_O [*2] |-> sel_w == 7'h00)
    else $error("selection while disabled");
  chk_start_enabled: assert property (s_start |-> CONV_ENABLE_O)
    else $error("start while disabled");
  chk_sel_frozen: assert property (s_start |=>
    ($stable(sel_w) || !CONV_ENABLE_O) [*8]) else $error("selection moved");
  chk_min_length: assert property (s_start |-> (CONV_BUSY_O || !CONV_ENABLE_O) [*8])
    else $error("conversion too short");
  chk_sample_busy: assert property (SAMPLE_HOLD_O |-> CONV_BUSY_O)
    else $error("sample outside conversion");
  chk_sample_pulse: assert property (SAMPLE_HOLD_O |=> !SAMPLE_HOLD_O)
    else $error("sample not a pulse");
  chk_sample_seen: assert property (s_start |-> ##[1:400] SAMPLE_HOLD_O)
    else $error("no sample");
  chk_flag_at_end: assert property (s_end |-> ##[0:1] CONV_DONE_FLAG_O)
    else $error("flag not set at end");
  chk_flag_cause: assert property ($rose(CONV_DONE_FLAG_O) |-> $past(CONV_BUSY_O))
    else $error("flag without conversion");
endmodule
bind acs_sequencer acs_sequencer_monitor u_mon (.CLOCK_I, .RESET_I, .PSEL_I, .PENABLE_I,
  .PADDR_I, .PREADY_O, .PSLVERR_O, .INPUT_CHANNEL_SELECT_O, .REFERENCE_SELECT_O,
  .CONV_ENABLE_O, .SAMPLE_HOLD_O, .CONV_BUSY_O, .CONV_DONE_FLAG_O);

// ===== bench/acs_core_model.sv
`timescale 1ns/1ps
module acs_core_model (
  input wire logic clk_i,
  input wire logic sample_i,
  input wire logic [4:0] chan_i,
  output logic [9:0] data_o,
  output logic diff_o
);
  int seed = 32'hC56E3B4D;
  logic [9:0] held = 10'h000;
  always @(posedge clk_i) begin
    if (sample_i === 1'b1) begin
      held <= 10'($random(seed));
    end
  end
  assign data_o = held;
  // Upper channel codes stand for differential pairs
  assign diff_o = chan_i[4];
endmodule

// ===== bench/acs_sequencer_tb_top.sv
`timescale 1ns/1ps
module acs_sequencer_tb_top import acs_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] trig = 8'h00;
  logic pready, pslverr, diff, en, sh, busy, flag, err;
  logic [9:0] cdata;
  logic [4:0] chan;
  logic [1:0] refs;
  logic [2:0] ch, ps;
  acs_result_t exp_r, old_r;
  int mismatches = 0, n_compared = 0, c;
  int seed = 32'hC56E3B4D;
  always #20 clk = ~clk;
  acs_sequencer u_dut (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .TRIGGER_I(trig),
    .CONV_DATA_I(cdata), .DIFF_CHANNEL_I(diff), .INPUT_CHANNEL_SELECT_O(chan),
    .REFERENCE_SELECT_O(refs), .CONV_ENABLE_O(en), .SAMPLE_HOLD_O(sh),
    .CONV_BUSY_O(busy), .CONV_DONE_FLAG_O(flag));
  acs_core_model u_core (.clk_i(clk), .sample_i(sh), .chan_i(chan), .data_o(cdata),
    .diff_o(diff));
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 2000) begin
      mismatches++;
      $display("FAIL %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    tmo(k);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0);
    chk(rd, want);
  endtask
  task automatic wait_for(input logic lvl);
    for (c = 0; c < 2000; c++) begin
      @(posedge clk);
      if (busy === lvl) break;
    end
    tmo(c);
  endtask
  function automatic int div(input logic [2:0] p);
    return (p == 3'h0) ? 2 : (1 << p);
  endfunction
  function automatic logic [31:0] res(input acs_result_t r, input logic la, input logic hi);
    if (la) return hi ? {24'h0, r[9:2]} : {24'h0, r[1:0], 6'h00};
    return hi ? {30'h0, r[9:8]} : {24'h0, r[7:0]};
  endfunction
  // Busy length in cycles within one cycle of ticks times the divider
  task automatic len(input int t);
    chk(32'(c + 1 >= t * div(ps) - 1 && c + 1 <= t * div(ps) + 1), 32'h1);
  endtask
  task automatic conv(input logic [7:0] ctl, input int t);
    ps = ctl[2:0];
    apb(1'b1, 12'h000, {24'h0, ctl});
    wait_for(1'b1);
    wait_for(1'b0);
    len(t);
    exp_r = u_core.held;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rdchk(12'(i * 4), 32'h0);
      chk(32'(err), 32'(i == 5));
    end
    apb(1'b1, 12'h040, 32'hFF);
    chk(32'(err), 32'h1);
    ch = 3'($random(seed));
    apb(1'b1, 12'h008, {24'h0, 8'h40 | 8'(ch)});
    repeat (3) @(posedge clk);
    chk(32'({refs, chan}), 32'h0);
    conv(8'hC1, 25);
    chk(32'({refs, chan}), 32'({4'h4, ch}));
    rdchk(12'h000, 32'h91);
    rdchk(12'h00C, res(exp_r, 1'b0, 1'b0));
    old_r = exp_r;
    apb(1'b1, 12'h000, 32'hD1);
    rdchk(12'h000, 32'hC1);
    apb(1'b1, 12'h008, {24'h0, 8'h40 | 8'(ch ^ 3'h7)});
    chk(32'(chan), 32'(ch));
    wait_for(1'b0);
    repeat (3) @(posedge clk);
    chk(32'(chan), 32'(ch ^ 3'h7));
    rdchk(12'h000, 32'h91);
    rdchk(12'h010, res(old_r, 1'b0, 1'b1));
    rdchk(12'h00C, res(old_r, 1'b0, 1'b0));
    rdchk(12'h010, res(old_r, 1'b0, 1'b1));
    apb(1'b1, 12'h008, {24'h0, 8'h60 | 8'(ch)});
    conv(8'hD2, 13);
    rdchk(12'h00C, res(exp_r, 1'b1, 1'b0));
    rdchk(12'h010, res(exp_r, 1'b1, 1'b1));
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h000, 32'hB1);
    ps = 3'h1;
    trig <= 8'h08;
    wait_for(1'b1);
    trig <= 8'h00;
    fork
      wait_for(1'b0);
      begin
        repeat (6) @(posedge clk);
        trig <= 8'h08;
      end
    join
    len(14);
    repeat (30) @(posedge clk);
    chk(32'(busy), 32'h0);
    trig <= 8'h00;
    apb(1'b1, 12'h000, 32'hF1);
    wait_for(1'b1);
    wait_for(1'b0);
    len(13);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'hF1);
    c = 0;
    repeat (300) begin
      @(posedge clk);
      if (sh === 1'b1) c++;
    end
    chk(32'(c >= 8), 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(32'(rd[6]), 32'h1);
    apb(1'b1, 12'h000, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'({en, busy, refs, chan}), 32'h0);
    conv(8'hC0 | 8'(($random(seed) & 1) + 1), 25);
    wrap_up();
  end
endmodule
